// ---- core/eth_ctrl_irq_enable_status.sv ----
/*
 * Interrupt enable and status registers of the Ethernet controller, with
 * the interrupt output and the serial register port crossing.
 * Assumes event inputs and the power event clear come from core-clock
 * logic, and register accesses arrive on the serial link clock.
 */
// Function
// RQ1: Bit 15 enables link change interrupt.
// RQ2: Bit 14 enables transmit done interrupt.
// RQ3: Bit 13 enables receive ready interrupt.
// RQ4: Bit 11 enables receive overrun interrupt.
// RQ5: Bit 9 enables transmit stopped interrupt.
// RQ6: Bit 8 enables receive stopped interrupt.
// RQ7: Bit 6 enables transmit space interrupt.
// RQ8: Bit 5 enables wake frame interrupt.
// RQ9: Bit 4 enables wake packet interrupt.
// RQ10: Bit 3 enables linkup wake interrupt.
// RQ11: Bit 2 enables energy wake interrupt.
// RQ12: Bit 1 enables serial bus error interrupt.
// RQ13: Bit 0 delays energy interrupt until ready.
// RQ14: Interrupt asserts when flag and enable match.
// RQ15: Reads keep flags; writing one clears.
// RQ16: Link change either way sets bit 15.
// RQ17: Transmit done sets bit 14.
// RQ18: Receive frame ready sets bit 13.
// RQ19: Receive overrun sets bit 11.
// RQ20: Flags latch on rising edge, stay set.
// RQ21: Stopped flags 9, 8 reset to one.
// RQ22: Transmit space available sets bit 6.
// RQ23: Serial bus error sets bit 1.
// RQ24: Wake flags cleared only by one-hot code.
// RQ25: Interrupt drops when no enabled flag remains.
// RQ26: Reserved bits read zero, ignore writes.
`timescale 1ns/100ps
`default_nettype none

module eth_ctrl_irq_enable_status
	import eth_irq_pkg::*;
(
	input  wire logic              clk,            // Core clock, 25 MHz.
	input  wire logic              rstn,           // Asynchronous reset, active low.
	input  wire logic              link_clk,       // Serial register port clock.
	input  wire logic              acc_wr,         // Register write pulse, link clock.
	input  wire logic              acc_rd,         // Register read pulse, link clock.
	input  wire logic [ADDR_W-1:0] acc_addr,       // Register byte offset.
	input  wire logic [DATA_W-1:0] acc_wdata,      // Register write data.
	output logic      [DATA_W-1:0] acc_rdata,      // Register read data.
	output logic                   acc_busy,       // Access in flight.
	input  wire logic              link_up,        // Link status level.
	input  wire logic              tx_done_ev,     // Frame sent, queue ready.
	input  wire logic              rx_ready_ev,    // Received frame ready.
	input  wire logic              rx_overrun_ev,  // Receive overrun.
	input  wire logic              tx_stopped_ev,  // Transmit process stopped.
	input  wire logic              rx_stopped_ev,  // Receive process stopped.
	input  wire logic              tx_space_ev,    // Transmit space available.
	input  wire logic              wake_frame_ev,  // Wake-up frame seen.
	input  wire logic              wake_packet_ev, // Wake packet seen.
	input  wire logic              linkup_wake_ev, // Wake on link up.
	input  wire logic              energy_wake_ev, // Wake on energy.
	input  wire logic              serial_bus_err_ev, // Serial bus error.
	input  wire logic              host_ready,     // Device ready for host access.
	input  wire logic              pm_clr_stb,     // Power event field written.
	input  wire logic [3:0]        pm_clr_code,    // Power event field value.
	output logic                   irq_out         // Interrupt, active high.
);

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		logic              req_s1;
		logic              req_s2;
		logic              req_seen;
		logic              ack_tgl;
		logic [DATA_W-1:0] en;
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] ev_prev;
		logic [DATA_W-1:0] rdata;
		logic              irq;
	} core_state_t;

	localparam core_state_t CORE_RESET = '{
		req_s1:   1'b0,
		req_s2:   1'b0,
		req_seen: 1'b0,
		ack_tgl:  1'b0,
		en:       EN_RESET,
		flags:    STATUS_RESET,
		ev_prev:  16'h0000,
		rdata:    16'h0000,
		irq:      1'b0
	};

	core_state_t s;
	core_state_t n;

	logic              req_tgl;
	logic              req_wr;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_wdata;
	logic              new_req;
	logic              do_wr;
	logic              do_rd;
	logic [DATA_W-1:0] lvl;
	logic [DATA_W-1:0] rise;
	logic [DATA_W-1:0] set_v;
	logic [DATA_W-1:0] clr_v;
	logic [DATA_W-1:0] live;
	logic [DATA_W-1:0] pend_v;
	logic              pend;

	// -----------------------------------------------------------------
	// Decode helpers
	// -----------------------------------------------------------------
	function automatic logic hit_enable(input logic [ADDR_W-1:0] a);
		hit_enable = (a == IRQ_ENABLE_OFFSET);
	endfunction

	function automatic logic hit_status(input logic [ADDR_W-1:0] a);
		hit_status = (a == IRQ_STATUS_OFFSET);
	endfunction

	// Maps the power event field to the wake flag it clears. Only an exact
	// one-hot code clears; any other value clears nothing.
	function automatic logic [DATA_W-1:0] wake_clear(input logic [3:0] c);
		wake_clear = 16'h0000;
		case (c)
			PM_CODE_WAKE_FRAME:  wake_clear[BIT_WAKE_FRAME]  = 1'b1;
			PM_CODE_WAKE_PACKET: wake_clear[BIT_WAKE_PACKET] = 1'b1;
			PM_CODE_LINKUP_WAKE: wake_clear[BIT_LINKUP_WAKE] = 1'b1;
			PM_CODE_ENERGY_WAKE: wake_clear[BIT_ENERGY_WAKE] = 1'b1;
			default:             wake_clear = 16'h0000;
		endcase
	endfunction

	// -----------------------------------------------------------------
	// Link-clock register port
	// -----------------------------------------------------------------
	link_reg_port i_link_reg_port (
		.link_clk   (link_clk),
		.rstn       (rstn),
		.acc_wr     (acc_wr),
		.acc_rd     (acc_rd),
		.acc_addr   (acc_addr),
		.acc_wdata  (acc_wdata),
		.acc_rdata  (acc_rdata),
		.acc_busy   (acc_busy),
		.req_tgl    (req_tgl),
		.req_wr     (req_wr),
		.req_addr   (req_addr),
		.req_wdata  (req_wdata),
		.ack_tgl    (s.ack_tgl),
		.core_rdata (s.rdata)
	);

	// -----------------------------------------------------------------
	// Request decode
	// -----------------------------------------------------------------
	// The held address and data are read only after the request toggle has
	// passed two flip-flops, so they are stable by then.
	assign new_req = s.req_s2 ^ s.req_seen;
	assign do_wr   = new_req & req_wr;
	assign do_rd   = new_req & ~req_wr;

	// -----------------------------------------------------------------
	// Event levels and edges
	// -----------------------------------------------------------------
	// Link change is flagged on either edge; every other source on its
	// rising edge only, so a level held high raises one flag.
	always_comb begin
		lvl = 16'h0000;
		lvl[BIT_LINK_CHANGE]    = link_up;
		lvl[BIT_TX_DONE]        = tx_done_ev;
		lvl[BIT_RX_READY]       = rx_ready_ev;
		lvl[BIT_RX_OVERRUN]     = rx_overrun_ev;
		lvl[BIT_TX_STOPPED]     = tx_stopped_ev;
		lvl[BIT_RX_STOPPED]     = rx_stopped_ev;
		lvl[BIT_TX_SPACE]       = tx_space_ev;
		lvl[BIT_WAKE_FRAME]     = wake_frame_ev;
		lvl[BIT_WAKE_PACKET]    = wake_packet_ev;
		lvl[BIT_LINKUP_WAKE]    = linkup_wake_ev;
		lvl[BIT_ENERGY_WAKE]    = energy_wake_ev;
		lvl[BIT_SERIAL_BUS_ERR] = serial_bus_err_ev;
		rise = lvl & ~s.ev_prev; // see RQ20
		rise[BIT_LINK_CHANGE] = lvl[BIT_LINK_CHANGE] ^ s.ev_prev[BIT_LINK_CHANGE]; // see RQ16
	end

	// Sources for bits 14, 13, 11, 9, 8, 6 and 1 all pass the same mask.
	assign set_v = rise & STATUS_MASK; // see RQ17 see RQ18 see RQ19 see RQ22 see RQ23

	// -----------------------------------------------------------------
	// Clear terms
	// -----------------------------------------------------------------
	// Register writes clear only the write-one-to-clear bits; the wake bits
	// ignore them and fall only to the power event code.
	always_comb begin
		clr_v = 16'h0000;
		if (do_wr && hit_status(req_addr)) begin
			clr_v = req_wdata & W1C_MASK; // see RQ15
		end
		if (pm_clr_stb) begin
			clr_v = clr_v | wake_clear(pm_clr_code); // see RQ24
		end
	end

	// -----------------------------------------------------------------
	// Interrupt term
	// -----------------------------------------------------------------
	// With the delayed energy enable set, the energy wake flag is held
	// back from the output until the device is ready for host access.
	always_comb begin
		live = STATUS_MASK;
		if (s.en[BIT_DELAYED_ENERGY] && !host_ready) begin
			live[BIT_ENERGY_WAKE] = 1'b0; // see RQ13
		end
	end

	// Each enable bit gates the flag in the same position.
	assign pend_v = s.flags & s.en & live; // see RQ1 see RQ2 see RQ3 see RQ4 see RQ5 see RQ6
	assign pend   = |pend_v; // see RQ7 see RQ8 see RQ9 see RQ10 see RQ11 see RQ12

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		n = s;
		n.req_s1  = req_tgl;
		n.req_s2  = s.req_s1;
		n.ev_prev = lvl;
		// Set wins over a clear that lands in the same cycle.
		n.flags = ((s.flags & ~clr_v) | set_v) & STATUS_MASK; // see RQ20 see RQ26
		n.irq   = pend; // see RQ14 see RQ25
		if (new_req) begin
			n.req_seen = s.req_s2;
			n.ack_tgl  = ~s.ack_tgl;
			// Reads never touch the flags; the answer is the value before
			// any write of the same access.
			if (hit_enable(req_addr)) begin
				n.rdata = s.en;
			end else if (hit_status(req_addr)) begin
				n.rdata = s.flags; // see RQ15
			end else begin
				n.rdata = 16'h0000;
			end
			if (do_wr && hit_enable(req_addr)) begin
				n.en = req_wdata & EN_MASK; // see RQ26
			end
		end
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	// Stopped-process flags leave reset set, as the reset value says.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= CORE_RESET; // see RQ21
		end else begin
			s <= n;
		end
	end

	assign irq_out = s.irq;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!rstn);

	a_link_change_set: assert property ( // see RQ16
		(link_up != s.ev_prev[BIT_LINK_CHANGE]) |=> s.flags[BIT_LINK_CHANGE])
		else $error("Link change did not set its flag.");

	a_overrun_w1c: assert property ( // see RQ15
		(do_wr && hit_status(req_addr) && req_wdata[BIT_RX_OVERRUN]
			&& !(rx_overrun_ev && !s.ev_prev[BIT_RX_OVERRUN]))
		|=> !s.flags[BIT_RX_OVERRUN])
		else $error("Write one did not clear the overrun flag.");

	a_read_keeps_flags: assert property ( // see RQ15
		(do_rd && !pm_clr_stb) |=> (($past(s.flags) & ~s.flags) == 16'h0000))
		else $error("A read cleared a status flag.");

	a_irq_asserts: assert property ( // see RQ14
		pend |=> irq_out)
		else $error("Enabled flag did not raise the interrupt.");

	a_irq_drops: assert property ( // see RQ25
		!pend |=> !irq_out)
		else $error("Interrupt stayed high with no enabled flag.");

	a_rx_ready_sticky: assert property ( // see RQ20
		(s.flags[BIT_RX_READY] && !(do_wr && hit_status(req_addr)))
		|=> s.flags[BIT_RX_READY] [*1])
		else $error("Receive ready flag fell without a clear.");

	a_wake_ignores_w1c: assert property ( // see RQ24
		(!pm_clr_stb) |=> (($past(s.flags[5:2]) & ~s.flags[5:2]) == 4'h0))
		else $error("Wake flag cleared without the power event code.");

	a_reserved_zero: assert property ( // see RQ26
		((s.flags & ~STATUS_MASK) == 16'h0000) && ((s.en & ~EN_MASK) == 16'h0000))
		else $error("A reserved bit holds a one.");

	a_enable_write: assert property ( // see RQ1
		(do_wr && hit_enable(req_addr)) |=> (s.en == ($past(req_wdata) & EN_MASK)))
		else $error("Enable register did not take the written value.");

	a_energy_withheld: assert property ( // see RQ13
		(s.en[BIT_DELAYED_ENERGY] && !host_ready
			&& ((s.flags & s.en & ~(16'h0001 << BIT_ENERGY_WAKE)) == 16'h0000))
		|=> !irq_out)
		else $error("Delayed energy interrupt reached the output early.");

endmodule
`default_nettype wire

// ---- core/eth_irq_pkg.sv ----
/*
 * Constants for the interrupt enable and status block: register offsets,
 * field positions, masks and reset values.
 * Assumes a 16-bit register word reached through the serial register port.
 */
package eth_irq_pkg;

	// -----------------------------------------------------------------
	// Register port geometry
	// -----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h90;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h92;

	// -----------------------------------------------------------------
	// Field positions, shared by enable and status except bit 0, which is enable only
	// -----------------------------------------------------------------
	localparam int BIT_LINK_CHANGE    = 15;
	localparam int BIT_TX_DONE        = 14;
	localparam int BIT_RX_READY       = 13;
	localparam int BIT_RX_OVERRUN     = 11;
	localparam int BIT_TX_STOPPED     = 9;
	localparam int BIT_RX_STOPPED     = 8;
	localparam int BIT_TX_SPACE       = 6;
	localparam int BIT_WAKE_FRAME     = 5;
	localparam int BIT_WAKE_PACKET    = 4;
	localparam int BIT_LINKUP_WAKE    = 3;
	localparam int BIT_ENERGY_WAKE    = 2;
	localparam int BIT_SERIAL_BUS_ERR = 1;
	localparam int BIT_DELAYED_ENERGY = 0;

	// -----------------------------------------------------------------
	// Masks and reset values
	// -----------------------------------------------------------------
	localparam logic [15:0] EN_MASK      = 16'heb7f;
	localparam logic [15:0] W1C_MASK     = 16'heb42;
	localparam logic [15:0] WAKE_MASK    = 16'h003c;
	localparam logic [15:0] STATUS_MASK  = 16'heb7e;
	localparam logic [15:0] EN_RESET     = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0300;

	// One-hot clear codes for the power event control field.
	localparam logic [3:0] PM_CODE_WAKE_FRAME  = 4'h8;
	localparam logic [3:0] PM_CODE_WAKE_PACKET = 4'h4;
	localparam logic [3:0] PM_CODE_LINKUP_WAKE = 4'h2;
	localparam logic [3:0] PM_CODE_ENERGY_WAKE = 4'h1;

endpackage

// ---- core/link_reg_port.sv ----
/*
 * Link-clock end of the register port: captures one access at a time and
 * hands it to the core clock with a toggle handshake.
 * Assumes the core side holds its answer word stable until the next request.
 */
`timescale 1ns/100ps
`default_nettype none

module link_reg_port
	import eth_irq_pkg::*;
(
	input  wire logic              link_clk,  // Serial port clock.
	input  wire logic              rstn,      // Asynchronous reset, active low.
	input  wire logic              acc_wr,    // Write request pulse.
	input  wire logic              acc_rd,    // Read request pulse.
	input  wire logic [ADDR_W-1:0] acc_addr,  // Register byte offset.
	input  wire logic [DATA_W-1:0] acc_wdata, // Write data.
	output logic      [DATA_W-1:0] acc_rdata, // Read data of last access.
	output logic                   acc_busy,  // Access in flight.
	output logic                   req_tgl,   // Request toggle to core.
	output logic                   req_wr,    // Held write flag.
	output logic      [ADDR_W-1:0] req_addr,  // Held offset.
	output logic      [DATA_W-1:0] req_wdata, // Held write data.
	input  wire logic              ack_tgl,   // Acknowledge toggle from core.
	input  wire logic [DATA_W-1:0] core_rdata // Core answer word.
);

	typedef struct packed {
		logic              req;
		logic              ack_s1;
		logic              ack_s2;
		logic              ack_seen;
		logic              busy;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
	} link_state_t;

	localparam link_state_t LINK_RESET = '0;

	link_state_t s;
	link_state_t n;

	// -----------------------------------------------------------------
	// Request capture and acknowledge detection
	// -----------------------------------------------------------------
	// Requests during busy are dropped; held fields must stay stable while
	// the core samples them after its synchroniser.
	always_comb begin
		n = s;
		n.ack_s1 = ack_tgl;
		n.ack_s2 = s.ack_s1;
		if (s.busy && (s.ack_s2 != s.ack_seen)) begin
			n.ack_seen = s.ack_s2;
			n.busy = 1'b0;
			n.rdata = core_rdata;
		end else if (!s.busy && (acc_wr || acc_rd)) begin
			n.wr = acc_wr;
			n.addr = acc_addr;
			n.wdata = acc_wdata;
			n.busy = 1'b1;
			n.req = ~s.req;
		end
	end

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			s <= LINK_RESET;
		end else begin
			s <= n;
		end
	end

	assign acc_rdata = s.rdata;
	assign acc_busy  = s.busy;
	assign req_tgl   = s.req;
	assign req_wr    = s.wr;
	assign req_addr  = s.addr;
	assign req_wdata = s.wdata;

	a_busy_on_request: assert property ( // see RQ15
		@(posedge link_clk) disable iff (!rstn)
		(!s.busy && (acc_wr || acc_rd)) |=> (s.busy && $changed(s.req)))
		else $error("Accepted access did not raise busy and toggle request.");

endmodule
`default_nettype wire

// ---- sim/host_model.sv ----
/*
 * Host model for the register port: it issues one word access at a time
 * and returns the answer word.
 * Assumes the port takes a request at a rising link clock edge while idle
 * and raises busy until its answer is ready.
 */
`timescale 1ns/100ps
`default_nettype none

module host_model
	import eth_irq_pkg::*;
(
	input  wire logic              link_clk,  // Register port clock.
	output logic                   acc_wr,    // Write request pulse.
	output logic                   acc_rd,    // Read request pulse.
	output logic      [ADDR_W-1:0] acc_addr,  // Register offset.
	output logic      [DATA_W-1:0] acc_wdata, // Write data.
	input  wire logic [DATA_W-1:0] acc_rdata, // Answer word.
	input  wire logic              acc_busy   // Access in flight.
);
	// ---------------------------------------------------------------
	// Access sequencing
	// ---------------------------------------------------------------

	// Idle request lines at time zero.
	initial begin
		acc_wr    = 1'b0;
		acc_rd    = 1'b0;
		acc_addr  = 8'h00;
		acc_wdata = 16'h0000;
	end

	// The request is set at a falling edge and taken at the next rising one.
	// Offset and data are inverted afterwards, so a port that samples them
	// late sees a wrong value rather than a lucky stale one. A port that
	// never answers is left to the bench's cycle ceiling.
	task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
		input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata);
		@(negedge link_clk);
		acc_wr    = wr;
		acc_rd    = ~wr;
		acc_addr  = addr;
		acc_wdata = wdata;
		@(negedge link_clk);
		acc_wr    = 1'b0;
		acc_rd    = 1'b0;
		acc_addr  = ~addr;
		acc_wdata = ~wdata;
		while (acc_busy !== 1'b0) begin
			@(negedge link_clk);
		end
		rdata = acc_rdata;
	endtask
endmodule

`default_nettype wire

// ---- sim/test_eth_ctrl_irq_enable_status.sv ----
/*
 * Self-checking bench for the interrupt enable and status block.
 * Assumes the host model in sim/ and the package constants; events and
 * the power event clear are driven on falling core clock edges.
 */
`timescale 1ns/100ps
`default_nettype none

module test_eth_ctrl_irq_enable_status
	import eth_irq_pkg::*;
;
	logic        clk      = 1'b0;
	logic        link_clk = 1'b0;
	logic        rstn;
	logic [15:0] ev;
	logic        host_ready;
	logic        pm_clr_stb;
	logic [3:0]  pm_clr_code;
	logic        acc_wr;
	logic        acc_rd;
	logic [7:0]  acc_addr;
	logic [15:0] acc_wdata;
	logic [15:0] acc_rdata;
	logic        acc_busy;
	logic        irq_out;
	int          err_total = 0;
	int          checks    = 0;
	int          cyc       = 0;
	int          w1c[8]    = '{15, 14, 13, 11, 9, 8, 6, 1};

	// ---------------------------------------------------------------
	// Clocks, design and host
	// ---------------------------------------------------------------

	// Core clock, 40 ns period.
	always #20 clk = ~clk;

	// Link clock, 30 ns period, offset so its edges drift against the core.
	initial begin
		#7;
		forever #15 link_clk = ~link_clk;
	end

	eth_ctrl_irq_enable_status i_eth_ctrl_irq_enable_status (
		.clk(clk), .rstn(rstn), .link_clk(link_clk),
		.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_busy(acc_busy),
		.link_up(ev[15]), .tx_done_ev(ev[14]), .rx_ready_ev(ev[13]),
		.rx_overrun_ev(ev[11]), .tx_stopped_ev(ev[9]), .rx_stopped_ev(ev[8]),
		.tx_space_ev(ev[6]), .wake_frame_ev(ev[5]), .wake_packet_ev(ev[4]),
		.linkup_wake_ev(ev[3]), .energy_wake_ev(ev[2]),
		.serial_bus_err_ev(ev[1]), .host_ready(host_ready),
		.pm_clr_stb(pm_clr_stb), .pm_clr_code(pm_clr_code), .irq_out(irq_out));

	host_model i_host_model (
		.link_clk(link_clk), .acc_wr(acc_wr), .acc_rd(acc_rd),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
		.acc_busy(acc_busy));

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------

	task automatic end_sim();
		$display("Totals: %0d comparisons, %0d mismatches", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		logic [15:0] d;
		i_host_model.access(1'b0, a, 16'h0000, d);
		chk(what, exp, d);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		i_host_model.access(1'b1, a, d, q);
	endtask

	// A few core cycles let the flag and the registered output settle.
	task automatic irq(input logic exp);
		repeat (3) @(negedge clk);
		chk("irq_out", {15'h0000, exp}, {15'h0000, irq_out});
	endtask

	// The event drops again before the flag is read, so latching shows.
	task automatic pulse(input int b);
		@(negedge clk);
		ev[b] = 1'b1;
		repeat (2) @(negedge clk);
		ev[b] = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic pm_clear(input logic [3:0] c);
		@(negedge clk);
		pm_clr_stb  = 1'b1;
		pm_clr_code = c;
		@(negedge clk);
		pm_clr_stb  = 1'b0;
		pm_clr_code = ~c;
	endtask

	// Hang guard: the whole sequence needs under a thousand core cycles.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		logic [3:0] code;
		rstn        = 1'b0;
		ev          = 16'h0000;
		host_ready  = 1'b0;
		pm_clr_stb  = 1'b0;
		pm_clr_code = 4'h0;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);

		chk("acc_busy reset", 16'h0000, {15'h0000, acc_busy});
		rd(IRQ_ENABLE_OFFSET, 16'h0000, "enable reset");
		rd(IRQ_STATUS_OFFSET, 16'h0300, "status reset");
		irq(1'b0);
		wr(IRQ_ENABLE_OFFSET, 16'hffff);
		rd(IRQ_ENABLE_OFFSET, 16'heb7f, "enable bits");
		irq(1'b1);
		wr(IRQ_STATUS_OFFSET, 16'h0000);
		rd(IRQ_STATUS_OFFSET, 16'h0300, "zero write");
		wr(IRQ_STATUS_OFFSET, 16'h0200);
		rd(IRQ_STATUS_OFFSET, 16'h0100, "clear bit 9");
		wr(IRQ_STATUS_OFFSET, 16'hffff);
		rd(IRQ_STATUS_OFFSET, 16'h0000, "clear all");
		irq(1'b0);
		wr(8'h94, 16'hffff);
		rd(8'h94, 16'h0000, "unmapped");
		rd(IRQ_ENABLE_OFFSET, 16'heb7f, "enable kept");
		$display("Test reset and access done");

		// Write-one-to-clear flags, each gated by its own enable bit only.
		foreach (w1c[i]) begin
			pulse(w1c[i]);
			rd(IRQ_STATUS_OFFSET, 16'h1 << w1c[i], "flag set");
			wr(IRQ_ENABLE_OFFSET, ~(16'h1 << w1c[i]));
			irq(1'b0);
			wr(IRQ_ENABLE_OFFSET, 16'h1 << w1c[i]);
			irq(1'b1);
			wr(IRQ_STATUS_OFFSET, ~(16'h1 << w1c[i]));
			rd(IRQ_STATUS_OFFSET, 16'h1 << w1c[i], "flag kept");
			wr(IRQ_STATUS_OFFSET, 16'h1 << w1c[i]);
			irq(1'b0);
			rd(IRQ_STATUS_OFFSET, 16'h0000, "flag cleared");
		end
		$display("Test clearable flags done");

		// Wake flags ignore status writes and other codes.
		wr(IRQ_ENABLE_OFFSET, 16'h003c);
		for (int b = 5; b >= 2; b--) begin
			code = 4'h1 << (b - 2);
			pulse(b);
			rd(IRQ_STATUS_OFFSET, 16'h1 << b, "wake set");
			irq(1'b1);
			wr(IRQ_STATUS_OFFSET, 16'h003c);
			rd(IRQ_STATUS_OFFSET, 16'h1 << b, "wake w1c");
			pm_clear(~code);
			rd(IRQ_STATUS_OFFSET, 16'h1 << b, "wake wrong code");
			pm_clear(code);
			rd(IRQ_STATUS_OFFSET, 16'h0000, "wake cleared");
			irq(1'b0);
		end
		$display("Test wake flags done");

		// Delayed energy interrupt waits for the host-ready level.
		wr(IRQ_ENABLE_OFFSET, 16'h0005);
		pulse(2);
		irq(1'b0);
		@(negedge clk);
		host_ready = 1'b1;
		irq(1'b1);
		pm_clear(PM_CODE_ENERGY_WAKE);
		irq(1'b0);
		$display("Test delayed energy done");
		end_sim();
	end
endmodule

`default_nettype wire
